// File: verilog/icd_top.sv
/*
 Twelve-channel digital input unit: plain inputs, banked reads, edge
 interrupts, up and up/down counting with match stop, quadrature decoding.
 Assumes one clock at 40 MHz and configuration held steady by software.
*/
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Twelve input channels 0 to 11, each usable as a plain input.
// - Single channel read gives its present level, 0 low, 1 high.
// - Bank 0 gives channels 0-7; bank 1 gives 8-11 low, upper bits zero.
// - Interrupt channels pulse on rising, falling or both edges as chosen.
// - Quadrature decoder takes I and Q from any channel, updates the count.
// - Optional index channel; index select all ones means no index.
// - Index polarity zero is active low, non-zero active high.
// - Synch signals on the block still clear the decoder count.
// - Count moves by one on each qualifying edge of the chosen inputs.
// - Up-count edge selectable rising, falling or either.
// - Up/down mode uses two pins, one up, one down.
// - Down edge selectable independently of the up edge.
// - Match mode counts up and stops on any match event of the block.
// - Match mode loads the stop count, other match registers go to maximum.
// - Count readable at any time; clear command returns it to reset value.
module icd_top #(
    parameter int NUM_CH  = icd_pkg::NUM_CH,
    parameter int COUNT_W = icd_pkg::COUNT_W
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  clk_en,
    input  wire logic [NUM_CH-1:0]     input_ch,
    input  wire logic [3:0]            read_one_sel,
    output logic                       read_one_input,
    input  wire logic                  read_group_sel,
    output logic [7:0]                 read_input_group,
    input  wire logic [NUM_CH-1:0]     config_edge_irq,
    input  wire icd_pkg::icd_edge_type irq_edge_sel [NUM_CH],
    output logic [NUM_CH-1:0]          irq_event,
    input  wire icd_pkg::icd_mode_type count_mode,
    input  wire logic [3:0]            up_ch_sel,
    input  wire icd_pkg::icd_edge_type up_edge_sel,
    input  wire logic [3:0]            down_ch_sel,
    input  wire icd_pkg::icd_edge_type down_edge_sel,
    input  wire logic [COUNT_W-1:0]    match_value,
    input  wire logic                  config_load,
    input  wire logic [3:0]            quad_i_sel,
    input  wire logic [3:0]            quad_q_sel,
    input  wire logic [3:0]            index_sel,
    input  wire logic                  index_polarity,
    input  wire logic                  sync_clear,
    input  wire logic                  clear_count_value,
    output logic [COUNT_W-1:0]         read_count_value,
    output logic [COUNT_W-1:0]         match_stop,
    output logic [COUNT_W-1:0]         match_other,
    output logic                       count_stopped
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0] rise;
    logic [NUM_CH-1:0] fall;

    icd_sync #(.WIDTH(NUM_CH)) u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .din    (input_ch),
        .level  (level),
        .rise   (rise),
        .fall   (fall)
    );

    // ----------------------------------------------------------------
    // Plain reads and interrupt edges
    // ----------------------------------------------------------------
    logic              next_one;
    logic [7:0]        next_group;
    logic [NUM_CH-1:0] next_irq;
    logic [NUM_CH-1:0] irq_hit;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_irq
            icd_edge_sel u_irq_edge (
                .rise      (rise[g]),
                .fall      (fall[g]),
                .sel       (irq_edge_sel[g]),
                .event_out (irq_hit[g])
            );
        end
    endgenerate

    always_comb begin
        next_one   = read_one_input;
        next_group = read_input_group;
        next_irq   = irq_event;
        if (clk_en) begin
            // Out-of-range select reads low rather than wrapping
            next_one = (int'(read_one_sel) < NUM_CH) ? level[read_one_sel] : 1'b0;
            if (!read_group_sel) begin
                next_group = level[7:0];
            end else begin
                next_group = {4'h0, level[11:8]};
            end
            next_irq = irq_hit & config_edge_irq;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_one_input   <= 1'b0;
            read_input_group <= 8'h00;
            irq_event        <= '0;
        end else begin
            read_one_input   <= next_one;
            read_input_group <= next_group;
            irq_event        <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // Count events
    // ----------------------------------------------------------------
    logic up_hit;
    logic down_hit;
    logic [1:0] quad_prev;
    logic [1:0] quad_now;
    logic [1:0] next_quad_prev;
    logic quad_step_up;
    logic quad_step_down;
    logic index_active;

    icd_edge_sel u_up_edge (
        .rise      (rise[up_ch_sel]),
        .fall      (fall[up_ch_sel]),
        .sel       (up_edge_sel),
        .event_out (up_hit)
    );

    icd_edge_sel u_down_edge (
        .rise      (rise[down_ch_sel]),
        .fall      (fall[down_ch_sel]),
        .sel       (down_edge_sel),
        .event_out (down_hit)
    );

    assign quad_now = {level[quad_i_sel], level[quad_q_sel]};

    // Gray step: forward when I leads Q
    always_comb begin
        quad_step_up   = 1'b0;
        quad_step_down = 1'b0;
        case ({quad_prev, quad_now})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step_up   = 1'b1;
            4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step_down = 1'b1;
            default: begin
                quad_step_up   = 1'b0;
                quad_step_down = 1'b0;
            end
        endcase
        next_quad_prev = clk_en ? quad_now : quad_prev;
    end

    // Index off when select is all ones or out of range
    assign index_active = (index_sel != icd_pkg::INDEX_NONE) && (int'(index_sel) < NUM_CH)
                        && (level[index_sel] == (index_polarity != 1'b0));

    // ----------------------------------------------------------------
    // Count state
    // ----------------------------------------------------------------
    icd_pkg::icd_state_type state;
    icd_pkg::icd_state_type next_state;
    logic [COUNT_W-1:0]     next_count;
    logic [COUNT_W-1:0]     next_match_stop;
    logic [COUNT_W-1:0]     next_match_other;
    logic                   match_hit;

    // Any match register of the block equal to the count stops it
    assign match_hit = (read_count_value == match_stop) || (read_count_value == match_other);

    always_comb begin
        next_state       = state;
        next_count       = read_count_value;
        next_match_stop  = match_stop;
        next_match_other = match_other;
        if (clk_en) begin
            if (config_load) begin
                next_count = icd_pkg::COUNT_RESET;
                if (count_mode == icd_pkg::mode_count_stop_on_match) begin
                    next_match_stop  = match_value;
                    next_match_other = icd_pkg::MATCH_MAX;
                end
                next_state = icd_pkg::st_run;
            end else if (clear_count_value || sync_clear
                         || (count_mode == icd_pkg::mode_quad_decode && index_active)) begin
                // Clearing also restarts a stopped match count
                next_count = icd_pkg::COUNT_RESET;
                next_state = icd_pkg::st_run;
            end else begin
                case (state)
                    icd_pkg::st_run: begin
                        case (count_mode)
                            icd_pkg::mode_count_up: begin
                                if (up_hit) next_count = read_count_value + 1'b1;
                            end
                            icd_pkg::mode_count_updown: begin
                                // Coincident up and down cancel out
                                if (up_hit && !down_hit) begin
                                    next_count = read_count_value + 1'b1;
                                end else if (down_hit && !up_hit) begin
                                    next_count = read_count_value - 1'b1;
                                end
                            end
                            icd_pkg::mode_count_stop_on_match: begin
                                if (match_hit) begin
                                    next_state = icd_pkg::st_stopped;
                                end else if (up_hit) begin
                                    next_count = read_count_value + 1'b1;
                                end
                            end
                            default: begin
                                if (quad_step_up) begin
                                    next_count = read_count_value + 1'b1;
                                end else if (quad_step_down) begin
                                    next_count = read_count_value - 1'b1;
                                end
                            end
                        endcase
                    end
                    icd_pkg::st_stopped: next_state = icd_pkg::st_stopped;
                    default:             next_state = icd_pkg::st_run;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state            <= icd_pkg::st_idle;
            read_count_value <= icd_pkg::COUNT_RESET;
            match_stop       <= icd_pkg::MATCH_MAX;
            match_other      <= icd_pkg::MATCH_MAX;
            quad_prev        <= 2'b00;
        end else begin
            state            <= next_state;
            read_count_value <= next_count;
            match_stop       <= next_match_stop;
            match_other      <= next_match_other;
            quad_prev        <= next_quad_prev;
        end
    end

    assign count_stopped = (state == icd_pkg::st_stopped);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && clear_count_value && !config_load) |=> (read_count_value == 16'h0000);
    endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");

    property p_bank1;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && read_group_sel) |=> (read_input_group[7:4] == 4'h0);
    endproperty
    a_bank1: assert property (p_bank1) else $error("bank 1 upper bits set");

    property p_single;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && read_one_sel == 4'h0) |=> (read_one_input == $past(level[0]));
    endproperty
    a_single: assert property (p_single) else $error("single read wrong");

    property p_irq;
        @(posedge clk) disable iff (!rst_n)
        irq_event[0] |-> $past(config_edge_irq[0] && (rise[0] || fall[0]));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without edge");

    property p_up;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && state == icd_pkg::st_run && count_mode == icd_pkg::mode_count_up && up_hit
         && !config_load && !clear_count_value && !sync_clear)
        |=> (read_count_value == $past(read_count_value) + 16'h0001);
    endproperty
    a_up: assert property (p_up) else $error("up count missed");

    property p_stop;
        @(posedge clk) disable iff (!rst_n)
        (count_stopped && !(clk_en && (clear_count_value || sync_clear || config_load)))
        |=> $stable(read_count_value);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");

    property p_load;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && config_load && count_mode == icd_pkg::mode_count_stop_on_match)
        |=> (match_other == 16'hFFFF && match_stop == $past(match_value));
    endproperty
    a_load: assert property (p_load) else $error("match registers not loaded");

    property p_sync;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && sync_clear && !config_load) |=> (read_count_value == 16'h0000);
    endproperty
    a_sync: assert property (p_sync) else $error("sync clear ignored");

    c_stop: cover property (@(posedge clk) disable iff (!rst_n) $rose(count_stopped));
    c_down: cover property (@(posedge clk) disable iff (!rst_n)
        count_mode == icd_pkg::mode_count_updown && down_hit);
    c_quad: cover property (@(posedge clk) disable iff (!rst_n) quad_step_up ##1 quad_step_down);
endmodule
`default_nettype wire

// File: verilog/icd_pkg.sv
/*
 Package for the twelve-channel input counter and decoder: constants,
 mode and edge encodings shared by the design files.
 Assumes a single clock domain; nothing else.
*/
package icd_pkg;
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_CH      = 12;
    localparam int CH_SEL_W    = 4;
    localparam int COUNT_W     = 16;
    localparam int BANK_W      = 8;
    localparam int NUM_MATCH   = 2;

    // ----------------------------------------------------------------
    // Reset values and fixed figures
    // ----------------------------------------------------------------
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] MATCH_MAX   = 16'hFFFF;
    localparam logic [3:0]  INDEX_NONE  = 4'hF;
    localparam logic [3:0]  BANK1_FIRST = 4'h8;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        count_edge_rising  = 2'h0,
        count_edge_falling = 2'h1,
        count_edge_any     = 2'h2
    } icd_edge_type;

    typedef enum logic [1:0] {
        mode_count_up            = 2'h0,
        mode_count_updown        = 2'h1,
        mode_count_stop_on_match = 2'h2,
        mode_quad_decode         = 2'h3
    } icd_mode_type;

    typedef enum logic [2:0] {
        st_run     = 3'b001,
        st_stopped = 3'b010,
        st_idle    = 3'b100
    } icd_state_type;
endpackage

// File: verilog/icd_edge_sel.sv
/*
 Edge qualifier: turns a rise and a fall pulse into one event by edge mode.
 Assumes synchronised pulses of one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module icd_edge_sel (
    input  wire logic               rise,
    input  wire logic               fall,
    input  wire icd_pkg::icd_edge_type sel,
    output logic                    event_out
);
    always_comb begin
        case (sel)
            icd_pkg::count_edge_rising:  event_out = rise;
            icd_pkg::count_edge_falling: event_out = fall;
            default:                     event_out = rise | fall;
        endcase
    end
endmodule
`default_nettype wire

// File: verilog/icd_sync.sv
/*
 Input synchroniser with edge pulses, one bit per channel.
 Assumes inputs asynchronous to clk; reset already synchronised.
*/
`timescale 1ns/100ps
`default_nettype none
module icd_sync #(
    parameter int WIDTH = 12
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_level;
    logic [WIDTH-1:0] next_prev;

    always_comb begin
        next_meta  = clk_en ? din : meta;
        next_level = clk_en ? meta : level;
        next_prev  = clk_en ? level : prev;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta  <= '0;
            level <= '0;
            prev  <= '0;
        end else begin
            meta  <= next_meta;
            level <= next_level;
            prev  <= next_prev;
        end
    end

    // One pulse per edge, only while enabled
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_edge
            assign rise[g] = clk_en & level[g] & ~prev[g];
            assign fall[g] = clk_en & ~level[g] & prev[g];
        end
    endgenerate
endmodule
`default_nettype wire

// File: testbench/icd_src_model.sv
/*
 Model of the external signal sources: switches and a quadrature encoder.
 Assumes the bench calls its tasks; pins change just after a falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module icd_src_model (
    input  wire logic        clk,
    output logic      [11:0] pins
);
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    initial pins = 12'h000;

    task automatic drive(input logic [3:0] ch, input logic v);
        @(negedge clk);
        pins[ch] = v;
    endtask

    task automatic drive_all(input logic [11:0] v);
        @(negedge clk);
        pins = v;
    endtask

    // Phase read back from the pins, so a step stays legal after any drive
    task automatic quad(input logic [3:0] ia, input logic [3:0] qa, input logic up);
        logic [1:0] p;
        @(negedge clk);
        p = {pins[qa], pins[ia] ^ pins[qa]};
        p = up ? p + 2'h1 : p - 2'h1;
        pins[ia] = p[1] ^ p[0];
        pins[qa] = p[1];
    endtask
endmodule
`default_nettype wire

// File: testbench/input_counter_decoder_tb.sv
/*
 Self-checking bench for the input counter and decoder.
 Assumes icd_pkg and icd_top compiled first; one 40 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module input_counter_decoder_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, reset_n, clk_en, read_one_input, read_group_sel, config_load;
    logic index_polarity, sync_clear, clear_count_value, count_stopped, idx_act;
    logic [11:0] pins, config_edge_irq, irq_event, pat;
    logic [3:0] read_one_sel, up_ch_sel, down_ch_sel, quad_i_sel, quad_q_sel, index_sel;
    logic [7:0] read_input_group;
    logic [15:0] match_value, read_count_value, match_stop, match_other, exp_cnt, seen, expv;
    icd_pkg::icd_edge_type irq_edge_sel [12];
    icd_pkg::icd_edge_type up_edge_sel, down_edge_sel;
    icd_pkg::icd_mode_type count_mode;
    logic o;
    logic [3:0] ch;
    int n_errors, check_count, i, k, r;
    integer seed = 54188;

    icd_src_model icd_src_model_inst (.clk(clk), .pins(pins));

    icd_top #(.NUM_CH(12), .COUNT_W(16)) icd_top_inst (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .input_ch(pins),
        .read_one_sel(read_one_sel), .read_one_input(read_one_input),
        .read_group_sel(read_group_sel), .read_input_group(read_input_group),
        .config_edge_irq(config_edge_irq), .irq_edge_sel(irq_edge_sel), .irq_event(irq_event),
        .count_mode(count_mode), .up_ch_sel(up_ch_sel), .up_edge_sel(up_edge_sel),
        .down_ch_sel(down_ch_sel), .down_edge_sel(down_edge_sel), .match_value(match_value),
        .config_load(config_load), .quad_i_sel(quad_i_sel), .quad_q_sel(quad_q_sel),
        .index_sel(index_sel), .index_polarity(index_polarity), .sync_clear(sync_clear),
        .clear_count_value(clear_count_value), .read_count_value(read_count_value),
        .match_stop(match_stop), .match_other(match_other), .count_stopped(count_stopped)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic hit(icd_pkg::icd_edge_type s, logic a, logic b);
        return (a != b) && (s == icd_pkg::count_edge_any || (s == icd_pkg::count_edge_rising) == b);
    endfunction

    function automatic logic [3:0] rnd_ch();
        return 4'($unsigned($random(seed)) % 12);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] want, input string msg);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, want);
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Three edges of latency plus margin; ends on a falling edge
    task automatic settle;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic load;
        config_load = 1'b1;
        @(negedge clk);
        config_load = 1'b0;
        settle;
        exp_cnt = 16'h0000;
    endtask

    task automatic tog(input logic [3:0] c);
        logic a;
        a = pins[c];
        icd_src_model_inst.drive(c, !a);
        if (c == up_ch_sel && hit(up_edge_sel, a, !a) &&
            !(count_mode == icd_pkg::mode_count_stop_on_match && exp_cnt == match_value)) begin
            exp_cnt = exp_cnt + 16'h0001;
        end
        if (count_mode == icd_pkg::mode_count_updown && c == down_ch_sel && hit(down_edge_sel, a, !a)) begin
            exp_cnt = exp_cnt - 16'h0001;
        end
        settle;
        chk(read_count_value, exp_cnt, "count");
    endtask

    task automatic qstep(input logic up);
        icd_src_model_inst.quad(quad_i_sel, quad_q_sel, up);
        if (idx_act) begin
            exp_cnt = 16'h0000;
        end else begin
            exp_cnt = up ? exp_cnt + 16'h0001 : exp_cnt - 16'h0001;
        end
        settle;
        chk(read_count_value, exp_cnt, "quad count");
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        close_out;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        check_count = 0;
        idx_act = 1'b0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        {read_one_sel, read_group_sel, config_load, sync_clear, clear_count_value} = '0;
        config_edge_irq = 12'h000;
        for (i = 0; i < 12; i++) begin
            irq_edge_sel[i] = icd_pkg::icd_edge_type'(2'(i % 3));
        end
        count_mode = icd_pkg::mode_count_up;
        {up_ch_sel, down_ch_sel, quad_i_sel, quad_q_sel} = {4'h0, 4'h1, 4'h0, 4'h4};
        up_edge_sel = icd_pkg::count_edge_rising;
        down_edge_sel = icd_pkg::count_edge_rising;
        match_value = 16'h0003;
        index_sel = icd_pkg::INDEX_NONE;
        index_polarity = 1'b1;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(read_count_value, 16'h0000, "count after reset");
        chk(match_stop, 16'hFFFF, "stop reg after reset");
        chk(match_other, 16'hFFFF, "other reg after reset");
        load;
        // Plain and banked reads, all-ones corner first
        for (k = 0; k < 3; k++) begin
            pat = (k == 0) ? 12'hFFF : 12'($random(seed));
            icd_src_model_inst.drive_all(pat);
            settle;
            for (i = 0; i < 13; i++) begin
                read_one_sel = 4'(i);
                repeat (2) @(negedge clk);
                chk({15'h0000, read_one_input}, {15'h0000, (i < 12) ? pat[i] : 1'b0}, "one input");
            end
            read_group_sel = 1'b0;
            repeat (2) @(negedge clk);
            chk({8'h00, read_input_group}, {8'h00, pat[7:0]}, "bank 0");
            read_group_sel = 1'b1;
            repeat (2) @(negedge clk);
            chk({8'h00, read_input_group}, {12'h000, pat[11:8]}, "bank 1");
        end
        // Edge interrupts, every edge code, some channels masked
        config_edge_irq = 12'($random(seed));
        for (i = 0; i < 36; i++) begin
            ch = rnd_ch();
            o = pins[ch];
            icd_src_model_inst.drive(ch, !o);
            seen = 16'h0000;
            repeat (6) begin
                @(negedge clk);
                seen = seen | {4'h0, irq_event};
            end
            expv = 16'h0000;
            expv[ch] = config_edge_irq[ch] & hit(irq_edge_sel[ch], o, !o);
            chk(seen, expv, "irq event");
        end
        // Up and up/down counting; wrap below zero on k = 3
        for (k = 0; k < 6; k++) begin
            count_mode = (k < 3) ? icd_pkg::mode_count_up : icd_pkg::mode_count_updown;
            up_edge_sel = icd_pkg::icd_edge_type'(2'(k % 3));
            down_edge_sel = icd_pkg::icd_edge_type'(2'(2 - k % 3));
            up_ch_sel = rnd_ch();
            down_ch_sel = 4'((up_ch_sel + 1 + $unsigned($random(seed)) % 11) % 12);
            load;
            if (k >= 3) begin
                tog(down_ch_sel);
            end
            for (i = 0; i < 10; i++) begin
                r = $unsigned($random(seed)) % 3;
                tog((r == 0) ? up_ch_sel : (r == 1) ? down_ch_sel : rnd_ch());
            end
        end
        // Enable low freezes sync and count; the held edge lands once enabled
        clk_en = 1'b0;
        o = pins[up_ch_sel];
        icd_src_model_inst.drive(up_ch_sel, !o);
        settle;
        chk(read_count_value, exp_cnt, "frozen count");
        clk_en = 1'b1;
        if (hit(up_edge_sel, o, !o)) begin
            exp_cnt = exp_cnt + 16'h0001;
        end
        settle;
        chk(read_count_value, exp_cnt, "count after enable");
        // Stop on match, then clear restarts
        count_mode = icd_pkg::mode_count_stop_on_match;
        up_edge_sel = icd_pkg::count_edge_any;
        match_value = 16'(2 + $unsigned($random(seed)) % 3);
        load;
        chk(match_stop, match_value, "stop reg");
        chk(match_other, 16'hFFFF, "other reg");
        repeat (7) tog(up_ch_sel);
        chk({15'h0000, count_stopped}, 16'h0001, "stopped");
        clear_count_value = 1'b1;
        @(negedge clk);
        clear_count_value = 1'b0;
        settle;
        exp_cnt = 16'h0000;
        chk(read_count_value, exp_cnt, "clear");
        tog(up_ch_sel);
        // Quadrature with sync clear and index in both polarities
        count_mode = icd_pkg::mode_quad_decode;
        quad_i_sel = rnd_ch();
        quad_q_sel = 4'((quad_i_sel + 4) % 12);
        ch = 4'((quad_i_sel + 8) % 12);
        index_sel = icd_pkg::INDEX_NONE;
        index_polarity = 1'b1;
        load;
        for (i = 0; i < 14; i++) begin
            qstep(1'($random(seed)));
        end
        sync_clear = 1'b1;
        @(negedge clk);
        sync_clear = 1'b0;
        settle;
        exp_cnt = 16'h0000;
        chk(read_count_value, exp_cnt, "sync clear");
        icd_src_model_inst.drive(ch, 1'b0);
        index_sel = ch;
        qstep(1'b1);
        qstep(1'b1);
        icd_src_model_inst.drive(ch, 1'b1);
        idx_act = 1'b1;
        qstep(1'b1);
        index_polarity = 1'b0;
        idx_act = 1'b0;
        qstep(1'b1);
        icd_src_model_inst.drive(ch, 1'b0);
        idx_act = 1'b1;
        qstep(1'b0);
        close_out;
    end
endmodule
`default_nettype wire
